/* common/rect_cfg.svh */
/*
  Constants of the rectifier status indicator: register offsets, reset values,
  fault-response codes, bit positions and timing figures.
  Assumes a 25 MHz system clock and a 32-bit APB register bus.
*/
`ifndef RECT_CFG_SVH
`define RECT_CFG_SVH

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define OFF_CTRL       8'h00
`define OFF_OC_RESP    8'h04
`define OFF_OT_RESP    8'h08
`define OFF_LIMIT      8'h0c
`define OFF_NV_LIMIT   8'h10
`define OFF_SAVE       8'h14
`define OFF_STATUS     8'h18
`define OFF_IRQ_STAT   8'h1c
`define OFF_IRQ_MASK   8'h20

// ************************************************************
// Codes, reset values and bit positions
// ************************************************************
`define OC_LATCHED     8'hc0
`define OC_HICCUP      8'hf8
`define OT_LATCHED     8'h80
`define OT_RESTART     8'hc0
`define LIMIT_RESET    16'h0000
`define CTRL_RESET     2'h0
`define MASK_RESET     5'h00
`define SAVE_BIT       0
`define IRQ_ALARM      0
`define IRQ_SHUTDOWN   1
`define IRQ_LATCHED    2
`define IRQ_OVERLOAD   3
`define IRQ_BAD_CODE   4

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS  40
`define PG_PULSE_NS    1000000
`define BLINK_HALF_NS  250000000

`endif

/* common/rect_pkg.sv */
/*
  Types of the rectifier status indicator: bus carriers, condition and
  indication groups, and the state records of each module.
  Assumes rect_cfg.svh is on the include path.
*/
package rect_pkg;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  // Conditions reported by the power stage, high while present
  typedef struct packed {
    logic thermal_alarm;
    logic thermal_shutdown;
    logic fuse_blown;
    logic boost_fail;
    logic ov_latched;
    logic ac_out_of_limits;
    logic ac_absent;
    logic overload;
    logic internal_fail;
    logic comm_fail;
  } cond_s;

  typedef struct packed {
    logic ac_ok;
    logic dc_ok;
    logic service;
    logic fault;
  } lamp_s;

  // Open-drain monitoring pins: fault, overtemp_warn_n, power_good_n, module_present_n
  typedef struct packed {
    logic fault;
    logic otw;
    logic pg;
    logic present;
  } mon_s;

  typedef struct packed {
    logic [31:0] cnt;
    logic        wave;
  } blink_st_s;

  typedef struct packed {
    logic [7:0] code;
  } resp_st_s;

  typedef struct packed {
    lamp_s       lamps;
    mon_s        drive_low;
    logic        out_on;
    logic        rs485;
    logic [3:0]  addr;
    logic [1:0]  ctrl;
    logic [15:0] limit;
    logic [15:0] nv_limit;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;
    logic [31:0] prdata;
    cond_s       prev;
  } top_st_s;

endpackage : rect_pkg

/* hw/blink_gen.sv */
/*
  Square-wave generator for lamp blinking and power-good pulsing.
  Assumes one clock; the wave restarts high whenever it is enabled.
*/
`timescale 1ns/100ps
module blink_gen
  import rect_pkg::*;
#(
  parameter int unsigned HALF_CYC = 32'd25000
)(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic en,
  output logic      wave
);

  blink_st_s st;
  blink_st_s next_st;

  // Count half periods and toggle the wave
  always_comb
  begin
    next_st = st;
    if (!en)
    begin
      next_st.cnt  = 32'h0;
      next_st.wave = 1'b1;
    end
    else if (st.cnt >= HALF_CYC - 32'h1)
    begin
      next_st.cnt  = 32'h0;
      next_st.wave = ~st.wave;
    end
    else
    begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      st <= '{cnt: 32'h0, wave: 1'b1};
    else
      st <= next_st;
  end

  assign wave = st.wave;

endmodule : blink_gen

/* hw/resp_code_reg.sv */
/*
  Fault-response code register that holds one of two legal codes.
  Assumes the write strobe is a one-cycle pulse from the bus slave.
*/
`timescale 1ns/100ps
module resp_code_reg
  import rect_pkg::*;
#(
  parameter logic [7:0] CODE_A    = 8'hc0,
  parameter logic [7:0] CODE_B    = 8'hf8,
  parameter logic [7:0] RESET_VAL = 8'hf8
)(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic [7:0]      code,
  output logic            reject
);

  resp_st_s st;
  resp_st_s next_st;
  logic     legal;

  // Keep only a legal code; flag any other write
  always_comb
  begin
    next_st = st;
    legal   = (wdata == CODE_A) || (wdata == CODE_B);
    reject  = wr && !legal;
    if (wr && legal)
      next_st.code = wdata;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      st <= '{code: RESET_VAL};
    else
      st <= next_st;
  end

  assign code = st.code;

endmodule : resp_code_reg

/* hw/rect_status_top.sv */
/*
  Rectifier status indicator: maps power-stage conditions onto four lamps and
  four open-drain monitoring pins, selects the protocol and output control,
  forms the bus address and holds settings behind an APB slave.
  Assumes conditions, straps and control pins are synchronous to clk_sys.
*/
// What this block does
// - Thermal alarm lights service lamp, lowers warning; shutdown adds fault, drops DC OK.
// - Warning pin stays high normally, goes low on the pre-shutdown thermal alarm.
// - Fuse, boost or latched overvoltage: fault lamp, fault and power-good low.
// - Input out of limits: AC lamp blinks, others off, power-good low.
// - Input absent: all lamps off, power-good low, fault and warning high.
// - Overload: DC lamp blinks, power-good pulses at 1 ms while overload lasts.
// - Non-shutdown fault: fault lamp and pin asserted, power lamps and power-good normal.
// - Service request in bus-managed mode blinks the service lamp only.
// - Communication failure in differential serial mode blinks the fault lamp only.
// - Standby keeps AC lamp only; bus-managed lowers power-good, serial releases power-good.
// - Module-present pin is held low in every condition.
// - Over-current response accepts only 0xc0 or 0xf8.
// - Over-temperature response accepts only 0x80 or 0xc0.
// - Non-volatile limit is stored only on the save command.
// - Address bits A3 to A0 come from unit then rack level selects.
// - Loaded protocol pin selects differential serial mode, otherwise analog/bus-managed.
// - In analog or bus-managed mode, on/off pin at ground turns output on.
// - In differential serial mode the interlock pin switches the output.
`timescale 1ns/100ps
`include "rect_cfg.svh"
module rect_status_top
#(
  parameter int unsigned PG_PULSE_CYC = `PG_PULSE_NS / `CLK_PERIOD_NS,
  parameter int unsigned BLINK_CYC    = `BLINK_HALF_NS / `CLK_PERIOD_NS
)(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire rect_pkg::apb_req_s apb_req,
  output rect_pkg::apb_rsp_s    apb_rsp,
  input  wire rect_pkg::cond_s  cond,
  input  wire logic             protocol_loaded,
  input  wire logic             on_off_n,
  input  wire logic             interlock,
  input  wire logic [1:0]       unit_level_select,
  input  wire logic [1:0]       rack_level_select,
  output logic [3:0]            bus_addr,
  output logic                  main_output_on,
  output rect_pkg::lamp_s       lamps,
  input  wire rect_pkg::mon_s   mon_i,
  output rect_pkg::mon_s        mon_o,
  output rect_pkg::mon_s        mon_oe,
  output logic                  irq
);
  import rect_pkg::*;

  top_st_s     st;
  top_st_s     next_st;
  logic        blink;
  logic        pg_wave;
  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        oc_rej;
  logic        ot_rej;
  logic [7:0]  oc_code;
  logic [7:0]  ot_code;
  logic        latched;
  logic        standby;
  logic [4:0]  irq_set;
  logic [4:0]  irq_clr;
  logic [31:0] rdata;

  // ************************************************************
  // Bus decode
  // ************************************************************

  // Setup and access phases of an APB transfer, zero wait states
  always_comb
  begin
    setup  = apb_req.psel && !apb_req.penable;
    access = apb_req.psel && apb_req.penable;
    wr     = access && apb_req.pwrite;
    rd     = access && !apb_req.pwrite;
    unique case (apb_req.paddr)
      `OFF_CTRL, `OFF_OC_RESP, `OFF_OT_RESP, `OFF_LIMIT, `OFF_NV_LIMIT,
      `OFF_SAVE, `OFF_STATUS, `OFF_IRQ_STAT, `OFF_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Read mux, sampled during setup so data stands from a flop in access
  always_comb
  begin
    unique case (apb_req.paddr)
      `OFF_CTRL:     rdata = {30'h0, st.ctrl};
      `OFF_OC_RESP:  rdata = {24'h0, oc_code};
      `OFF_OT_RESP:  rdata = {24'h0, ot_code};
      `OFF_LIMIT:    rdata = {16'h0, st.limit};
      `OFF_NV_LIMIT: rdata = {16'h0, st.nv_limit};
      `OFF_STATUS:   rdata = {8'h0, mon_i, st.lamps, st.out_on, st.rs485, st.addr, cond};
      `OFF_IRQ_STAT: rdata = {27'h0, st.irq_stat};
      `OFF_IRQ_MASK: rdata = {27'h0, st.irq_mask};
      default:       rdata = 32'h0;
    endcase
  end

  assign apb_rsp.prdata  = st.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access && (!mapped || oc_rej || ot_rej);

  // ************************************************************
  // Response codes and timers
  // ************************************************************

  resp_code_reg #(
    .CODE_A    (`OC_LATCHED),
    .CODE_B    (`OC_HICCUP),
    .RESET_VAL (`OC_HICCUP)
  ) u_oc_resp (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr      (wr && apb_req.paddr == `OFF_OC_RESP),
    .wdata   (apb_req.pwdata[7:0]),
    .code    (oc_code),
    .reject  (oc_rej)
  );

  resp_code_reg #(
    .CODE_A    (`OT_LATCHED),
    .CODE_B    (`OT_RESTART),
    .RESET_VAL (`OT_RESTART)
  ) u_ot_resp (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr      (wr && apb_req.paddr == `OFF_OT_RESP),
    .wdata   (apb_req.pwdata[7:0]),
    .code    (ot_code),
    .reject  (ot_rej)
  );

  blink_gen #(
    .HALF_CYC (BLINK_CYC)
  ) u_blink (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .en      (1'b1),
    .wave    (blink)
  );

  blink_gen #(
    .HALF_CYC (PG_PULSE_CYC)
  ) u_pg_pulse (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .en      (cond.overload),
    .wave    (pg_wave)
  );

  // ************************************************************
  // Next state: modes, indication, registers, interrupts
  // ************************************************************

  always_comb
  begin
    next_st      = st;
    latched      = cond.fuse_blown || cond.boost_fail || cond.ov_latched;
    standby      = !st.out_on;
    // Protocol strap and output control
    next_st.rs485  = protocol_loaded;
    next_st.out_on = protocol_loaded ? interlock : !on_off_n;
    next_st.addr   = {unit_level_select, rack_level_select};
    // Indication, most severe first
    next_st.lamps     = '{ac_ok: 1'b1, dc_ok: 1'b1, service: 1'b0, fault: 1'b0};
    next_st.drive_low = '{fault: 1'b0, otw: 1'b0, pg: 1'b0, present: 1'b1};
    if (cond.thermal_shutdown)
    begin
      next_st.lamps     = '{ac_ok: 1'b1, dc_ok: 1'b0, service: 1'b1, fault: 1'b1};
      next_st.drive_low = '{fault: 1'b1, otw: 1'b1, pg: 1'b1, present: 1'b1};
    end
    else if (latched)
    begin
      next_st.lamps     = '{ac_ok: 1'b1, dc_ok: 1'b0, service: 1'b0, fault: 1'b1};
      next_st.drive_low = '{fault: 1'b1, otw: 1'b0, pg: 1'b1, present: 1'b1};
    end
    else if (cond.ac_absent)
    begin
      next_st.lamps        = '0;
      next_st.drive_low.pg = 1'b1;
    end
    else if (cond.ac_out_of_limits)
    begin
      next_st.lamps        = '{ac_ok: blink, dc_ok: 1'b0, service: 1'b0, fault: 1'b0};
      next_st.drive_low.pg = 1'b1;
    end
    else if (standby)
    begin
      next_st.lamps        = '{ac_ok: 1'b1, dc_ok: 1'b0, service: 1'b0, fault: 1'b0};
      next_st.drive_low.pg = !st.rs485;
    end
    else if (cond.overload)
    begin
      next_st.lamps.dc_ok  = blink;
      next_st.drive_low.pg = !pg_wave;
    end
    else if (cond.thermal_alarm)
    begin
      next_st.lamps.service = 1'b1;
      next_st.drive_low.otw = 1'b1;
    end
    else if (cond.internal_fail)
    begin
      next_st.lamps.fault     = 1'b1;
      next_st.drive_low.fault = 1'b1;
    end
    else if (st.ctrl[1] && st.ctrl[0] && !st.rs485)
    begin
      next_st.lamps.service = blink;
    end
    else if (cond.comm_fail && st.rs485)
    begin
      next_st.lamps.fault = blink;
    end
    // Register writes
    if (wr && apb_req.paddr == `OFF_CTRL)
      next_st.ctrl = apb_req.pwdata[1:0];
    if (wr && apb_req.paddr == `OFF_LIMIT)
      next_st.limit = apb_req.pwdata[15:0];
    if (wr && apb_req.paddr == `OFF_SAVE && apb_req.pwdata[`SAVE_BIT])
      next_st.nv_limit = st.limit;
    if (wr && apb_req.paddr == `OFF_IRQ_MASK)
      next_st.irq_mask = apb_req.pwdata[4:0];
    if (setup)
      next_st.prdata = rdata;
    // Sticky events, set wins over read-clear
    irq_set                = '0;
    irq_set[`IRQ_ALARM]    = cond.thermal_alarm && !st.prev.thermal_alarm;
    irq_set[`IRQ_SHUTDOWN] = cond.thermal_shutdown && !st.prev.thermal_shutdown;
    irq_set[`IRQ_LATCHED]  = latched &&
                             !(st.prev.fuse_blown || st.prev.boost_fail || st.prev.ov_latched);
    irq_set[`IRQ_OVERLOAD] = cond.overload && !st.prev.overload;
    irq_set[`IRQ_BAD_CODE] = oc_rej || ot_rej;
    // Clear only what the read returned, so an event set during setup is kept
    irq_clr          = (rd && apb_req.paddr == `OFF_IRQ_STAT) ? st.prdata[4:0] : 5'h00;
    next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
    next_st.prev     = cond;
  end

  // ************************************************************
  // State register
  // ************************************************************

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st           <= '0;
      st.drive_low <= '{fault: 1'b0, otw: 1'b0, pg: 1'b1, present: 1'b1};
      st.ctrl      <= `CTRL_RESET;
      st.limit     <= `LIMIT_RESET;
      st.nv_limit  <= `LIMIT_RESET;
      st.irq_mask  <= `MASK_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Pins: open drain pulls low when enabled
  assign lamps          = st.lamps;
  assign mon_o          = '0;
  assign mon_oe         = st.drive_low;
  assign bus_addr       = st.addr;
  assign main_output_on = st.out_on;
  assign irq            = |(st.irq_stat & st.irq_mask);

  // ************************************************************
  // Assertions
  // ************************************************************

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  shutdown_pattern_a: assert property (cond.thermal_shutdown |=>
    (lamps == 4'b1011) && mon_oe.fault && mon_oe.otw && mon_oe.pg)
    else $error("thermal shutdown pattern wrong");

  warn_cause_a: assert property ($rose(mon_oe.otw) |->
    $past(cond.thermal_alarm || cond.thermal_shutdown))
    else $error("warning pin low without thermal cause");

  latched_pattern_a: assert property (latched && !cond.thermal_shutdown |=>
    (lamps == 4'b1001) && mon_oe.fault && mon_oe.pg && !mon_oe.otw)
    else $error("latched shutdown pattern wrong");

  ac_limits_a: assert property (cond.ac_out_of_limits && !cond.ac_absent &&
    !latched && !cond.thermal_shutdown |=> mon_oe.pg && !mon_oe.fault && !lamps.dc_ok)
    else $error("input out of limits pattern wrong");

  ac_absent_a: assert property (cond.ac_absent && !latched &&
    !cond.thermal_shutdown |=> (lamps == 4'b0000) && mon_oe.pg && !mon_oe.otw)
    else $error("input absent pattern wrong");

  present_low_a: assert property (mon_oe.present && !mon_o.present)
    else $error("module present not driven low");

  oc_code_a: assert property (oc_code == `OC_LATCHED || oc_code == `OC_HICCUP)
    else $error("illegal over-current response code");

  ot_code_a: assert property (ot_code == `OT_LATCHED || ot_code == `OT_RESTART)
    else $error("illegal over-temperature response code");

  nv_save_a: assert property ($changed(st.nv_limit) |->
    $past(wr && apb_req.paddr == `OFF_SAVE))
    else $error("stored limit changed without save");

  addr_follow_a: assert property ($past(rst_n) |-> bus_addr ==
    $past({unit_level_select, rack_level_select}))
    else $error("bus address not from level selects");

  output_ctrl_a: assert property ($past(rst_n) |-> main_output_on ==
    $past(protocol_loaded ? interlock : !on_off_n))
    else $error("main output control wrong");

  irq_sticky_a: assert property (irq_set[`IRQ_SHUTDOWN] |=> st.irq_stat[`IRQ_SHUTDOWN])
    else $error("shutdown event lost");

  shutdown_cov: cover property (cond.thermal_shutdown ##1 lamps.fault);
  overload_cov: cover property (cond.overload [*3] ##1 mon_oe.pg);
  bad_code_cov: cover property (oc_rej && access);
  irq_cov:      cover property ($rose(irq));

endmodule : rect_status_top

/* sim/shelf_monitor.sv */
/*
  Shelf controller model: selects the protocol, commands the main output
  and reads back the open-drain monitoring pins through their pull-ups.
  Assumes the bench drives serial_mode and want_on at clock edges.
*/
`timescale 1ns/100ps
module shelf_monitor
  import rect_pkg::*;
(
  input  wire logic           serial_mode,
  input  wire logic           want_on,
  input  wire rect_pkg::mon_s mon_o,
  input  wire rect_pkg::mon_s mon_oe,
  output logic                protocol_loaded,
  output logic                on_off_n,
  output logic                interlock,
  output rect_pkg::mon_s      mon_i
);
  // ************************************************************
  // Mode and output control
  // ************************************************************
  // Unconnected pin for analog/bus mode, resistor load for serial mode
  assign protocol_loaded = serial_mode;
  // Pin grounded to turn on; in serial mode it shows the opposite, so it must be ignored
  assign on_off_n = serial_mode ? want_on : ~want_on;
  // Interlock follows the request only in serial mode; otherwise it misleads on purpose
  assign interlock = serial_mode ? want_on : ~want_on;

  // ************************************************************
  // Open-drain pins with pull-ups
  // ************************************************************
  // A released pin floats high
  assign mon_i = (mon_oe & mon_o) | ~mon_oe;
endmodule : shelf_monitor

/* sim/tb.sv */
/*
  Self-checking bench of the rectifier status indicator: condition table,
  APB register checks, interrupts, blinking and pulsing, protocol modes.
  Assumes rect_cfg.svh on the include path and the shelf_monitor model.
*/
`timescale 1ns/100ps
`include "rect_cfg.svh"
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb;
  import rect_pkg::*;
  typedef struct packed {
    cond_s      c;
    logic [3:0] lm;
    logic [3:0] lv;
    logic [3:0] om;
    logic [3:0] ov;
  } row_s;

  logic        clk_sys = 1'b0;
  logic        rst_n;
  apb_req_s    req;
  apb_rsp_s    rsp;
  cond_s       cond;
  logic        serial_mode;
  logic        want_on;
  logic [1:0]  unit_sel;
  logic [1:0]  rack_sel;
  logic [3:0]  bus_addr;
  logic        out_on;
  lamp_s       lamps;
  mon_s        mon_i;
  mon_s        mon_o;
  mon_s        mon_oe;
  logic        irq;
  logic        protocol_loaded;
  logic        on_off_n;
  logic        interlock;
  logic [31:0] rd;
  logic        err;
  wire  [7:0]  obs = {lamps, mon_oe};
  int          num_errors = 0;
  int          checks = 0;
  // Condition, lamp mask, lamps, pin mask, pins pulled low
  row_s        rows [14] = '{
    '{10'h000, 4'hf, 4'hc, 4'hf, 4'h1}, '{10'h200, 4'hf, 4'he, 4'hf, 4'h5},
    '{10'h100, 4'hf, 4'hb, 4'hf, 4'hf}, '{10'h080, 4'hf, 4'h9, 4'hf, 4'hb},
    '{10'h040, 4'hf, 4'h9, 4'hf, 4'hb}, '{10'h020, 4'hf, 4'h9, 4'hf, 4'hb},
    '{10'h010, 4'h7, 4'h0, 4'hf, 4'h3}, '{10'h008, 4'hf, 4'h0, 4'hf, 4'h3},
    '{10'h004, 4'hb, 4'h8, 4'hd, 4'h1}, '{10'h002, 4'hf, 4'hd, 4'hf, 4'h9},
    '{10'h001, 4'hf, 4'hc, 4'hf, 4'h1}, '{10'h180, 4'hf, 4'hb, 4'hf, 4'hf},
    '{10'h208, 4'hf, 4'h0, 4'hf, 4'h3}, '{10'h014, 4'h7, 4'h0, 4'hf, 4'h3}};
  // Address, data, refused, read back
  logic [24:0] codes [6] = '{
    {8'h04, 8'hc0, 1'b0, 8'hc0}, {8'h04, 8'h12, 1'b1, 8'hc0},
    {8'h04, 8'hf8, 1'b0, 8'hf8}, {8'h08, 8'h80, 1'b0, 8'h80},
    {8'h08, 8'hf8, 1'b1, 8'h80}, {8'h08, 8'hc0, 1'b0, 8'hc0}};

  rect_status_top #(.PG_PULSE_CYC(8), .BLINK_CYC(4)) rect_status_top_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .cond(cond),
    .protocol_loaded(protocol_loaded), .on_off_n(on_off_n), .interlock(interlock),
    .unit_level_select(unit_sel), .rack_level_select(rack_sel), .bus_addr(bus_addr),
    .main_output_on(out_on), .lamps(lamps), .mon_i(mon_i), .mon_o(mon_o),
    .mon_oe(mon_oe), .irq(irq));

  shelf_monitor shelf_monitor_i (
    .serial_mode(serial_mode), .want_on(want_on), .mon_o(mon_o), .mon_oe(mon_oe),
    .protocol_loaded(protocol_loaded), .on_off_n(on_off_n), .interlock(interlock),
    .mon_i(mon_i));

  // ************************************************************
  // Clock, tasks and watchdog
  // ************************************************************
  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 50)
    begin
      num_errors++;
      stop_test();
    end
  endtask : apb

  // Counts the cycles in which one observed bit is high
  task automatic cnt(input int b, input int n, input int exp);
    int c;
    c = 0;
    repeat (n)
    begin
      @(posedge clk_sys);
      c += obs[b];
    end
    `CHK(c, exp)
  endtask : cnt

  task automatic stop_test();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // Watchdog against a hung handshake or wait
  initial
  begin
    tick(5000);
    num_errors++;
    stop_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    rst_n = 1'b0;
    req = '0;
    cond = '0;
    serial_mode = 1'b0;
    want_on = 1'b1;
    unit_sel = 2'b10;
    rack_sel = 2'b01;
    tick(10);
    #1;
    `CHK({lamps, mon_oe, out_on, irq}, 10'h00c)
    tick(6);
    rst_n <= 1'b1;
    tick(4);
    `CHK(bus_addr, 4'h9)
    `CHK(out_on, 1'b1)
    // Condition table
    foreach (rows[i])
    begin
      cond <= rows[i].c;
      tick(3);
      `CHK(lamps & rows[i].lm, rows[i].lv)
      `CHK(mon_oe & rows[i].om, rows[i].ov)
    end
    cond <= '0;
    // Reset values and response codes
    apb(`OFF_OC_RESP, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_00f8)
    apb(`OFF_OT_RESP, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_00c0)
    foreach (codes[i])
    begin
      apb(codes[i][24:17], 1'b1, {24'h0, codes[i][16:9]});
      `CHK(err, codes[i][8])
      apb(codes[i][24:17], 1'b0, 32'h0);
      `CHK(rd[7:0], codes[i][7:0])
    end
    apb(`OFF_IRQ_STAT, 1'b0, 32'h0);
    `CHK(rd[`IRQ_BAD_CODE], 1'b1)
    apb(`OFF_IRQ_STAT, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    apb(8'h24, 1'b1, 32'hffff_ffff);
    `CHK(err, 1'b1)
    apb(8'h24, 1'b0, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    // Non-volatile limit only on save
    apb(`OFF_LIMIT, 1'b1, 32'h1234);
    apb(`OFF_NV_LIMIT, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    apb(`OFF_SAVE, 1'b1, 32'h1);
    apb(`OFF_NV_LIMIT, 1'b0, 32'h0);
    `CHK(rd, 32'h1234)
    apb(`OFF_STATUS, 1'b0, 32'h0);
    `CHK(rd[23:20], 4'he)
    `CHK(rd[13:10], 4'h9)
    // Masked and unmasked interrupt events
    apb(`OFF_IRQ_MASK, 1'b1, 32'h2);
    cond <= 10'h100;
    tick(4);
    `CHK(irq, 1'b1)
    apb(`OFF_IRQ_STAT, 1'b0, 32'h0);
    `CHK(rd[`IRQ_SHUTDOWN], 1'b1)
    cond <= 10'h200;
    tick(4);
    `CHK(irq, 1'b0)
    apb(`OFF_IRQ_STAT, 1'b0, 32'h0);
    `CHK(rd[`IRQ_ALARM], 1'b1)
    // Service request blinks only the service lamp
    cond <= '0;
    apb(`OFF_CTRL, 1'b1, 32'h3);
    tick(3);
    cnt(5, 16, 8);
    `CHK({lamps & 4'hd, mon_oe}, 8'hc1)
    // Overload pulses power-good and blinks DC OK
    cond <= 10'h004;
    tick(20);
    cnt(1, 32, 16);
    cnt(6, 16, 8);
    `CHK(mon_oe[3:2], 2'b00)
    // Bus-managed standby
    cond <= '0;
    want_on <= 1'b0;
    tick(3);
    `CHK({out_on, lamps, mon_oe}, 9'h083)
    // Differential serial mode
    serial_mode <= 1'b1;
    want_on <= 1'b1;
    cond <= 10'h001;
    tick(3);
    `CHK(out_on, 1'b1)
    cnt(4, 16, 8);
    `CHK({lamps & 4'he, mon_oe}, 8'hc1)
    want_on <= 1'b0;
    tick(3);
    `CHK({out_on, lamps, mon_oe}, 9'h081)
    // Reset in mid-run: outputs and codes return to their reset values
    cond <= '0;
    rst_n <= 1'b0;
    tick(2);
    `CHK({lamps, mon_oe, out_on, irq}, 10'h00c)
    rst_n <= 1'b1;
    apb(`OFF_OC_RESP, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_00f8)
    stop_test();
  end
endmodule : tb
